// File: pkg/menu_button_a_setup_pkg.sv
// Package for the communication setup and control mode block.
`default_nettype none
package menu_button_a_setup_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses).
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_IFACE   = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_IPV4    = 8'h08;
  localparam logic [7:0] OFS_BAUD    = 8'h0c;
  localparam logic [7:0] OFS_CMD_LANGUAGE_ITEM    = 8'h10;
  localparam logic [7:0] OFS_MODE    = 8'h14;
  localparam logic [7:0] OFS_HOSTCMD = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;

  // ----------------------------------------------------------------------
  // Limits, steps, menu positions and reset values.
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_MAX        = 5'h1f;
  localparam logic [7:0] IP_STEP_COARSE  = 8'h0a;
  localparam logic [7:0] IP_STEP_FINE    = 8'h01;
  localparam logic [2:0] POS_BAUD_NORMAL = 3'h2;
  localparam logic [2:0] POS_BAUD_LAN    = 3'h5;
  localparam logic [2:0] POS_CMD_LANGUAGE_ITEM_NORMAL = 3'h3;
  localparam logic [2:0] POS_CMD_LANGUAGE_ITEM_LAN    = 3'h6;
  localparam logic [2:0] POS_IP_FIRST    = 3'h2;
  localparam logic [2:0] POS_IP_LAST     = 3'h4;
  localparam logic [2:0] POS_LAST_NORMAL = 3'h3;
  localparam logic [2:0] POS_LAST_LAN    = 3'h6;
  localparam logic [4:0] ADDR_RESET      = 5'h06;
  localparam int         WARN_TIME_MS    = 2000;
  localparam int         CLK_MHZ         = 250;
  localparam int         WARN_CYCLES     = WARN_TIME_MS * 1000 * CLK_MHZ;
  localparam int         BLINK_CYCLES    = 16;

  typedef enum logic [2:0] {
    IFACE_RS232, IFACE_RS485, IFACE_USB, IFACE_LAN, IFACE_OPT
  } iface_e;

  typedef enum logic [2:0] {
    BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
  } baud_e;

  typedef enum logic { CMD_LANGUAGE_ITEM_SCPI, legacy_cmd_set } cmd_language_item_e;

  typedef enum logic [1:0] { MODE_LOCAL, MODE_REMOTE, MODE_LOCKOUT } mode_e;

  typedef enum logic [1:0] {
    HCMD_NONE, HCMD_LOCAL, HCMD_REMOTE, HCMD_LOCKOUT
  } host_cmd_e;

  typedef struct packed {
    logic rot_sel_cw;
    logic rot_sel_ccw;
    logic rot_val_cw;
    logic rot_val_ccw;
    logic val_press;
    logic menu_button_a;
    logic back_button;
    logic fine_button;
    logic system_button;
  } panel_s;

endpackage : menu_button_a_setup_pkg
`default_nettype wire

// File: hdl/menu_button_a_setup.sv
// Communication setup menu and local, remote and lockout control.
//
// Function
// - One active interface among five choices.
// - Optional interface offered only with card.
// - Node address 0..31, larger values rejected.
// - Four 8-bit IPv4 fields, each 0..255.
// - IPv4 fields exposed only when LAN selected.
// - IPv4 step 10 coarse, 1 fine, button toggles.
// - Exactly five serial bit rates.
// - LAN forces 115200, no change allowed.
// - Legacy or SCPI; LAN/optional allow SCPI only.
// - Bit-rate item at step 2, 5 with LAN.
// - Language item at step 3, 6 with LAN.
// - Confirm toggles IP edit or, with value turn, advances interface; blinks display once.
// - Menu button leaves menu; back leaves IP edit first, else menu.
// - Local command executes, then goes remote.
// - Local query answered, stays local.
// - Remote lights indicator, blocks panel value edits and confirm (menu moves still work), warns 2s.
// - Remote returns local by system+press or command.
// - Lockout lights indicator, rejects panel value edits and confirm (menu moves still work), warns 2s.
// - Lockout leaves only by remote command or power.
// - Analog programming refuses host setpoints only.
`default_nettype none
module menu_button_a_setup #(
  parameter int WARN_CYCLES = menu_button_a_setup_pkg::WARN_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire menu_button_a_setup_pkg::panel_s panel_raw,
  input  wire logic                   card_present_raw,
  input  wire logic                   analog_prog_raw,
  input  wire logic                   host_cmd_valid,
  input  wire logic                   host_is_query,
  input  wire logic                   host_is_setpoint,
  output logic                        host_cmd_exec,
  output logic                        host_query_answer,
  output logic                        remote_led,
  output logic                        remote_warning,
  output logic                        lockout_warning,
  output logic                        blink,
  output logic                        menu_active,
  output logic [2:0]                  menu_pos,
  output logic                        fine_mode
);

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------
  localparam int NIN = $bits(menu_button_a_setup_pkg::panel_s) + 2;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] prev_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {panel_raw, card_present_raw, analog_prog_raw};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  menu_button_a_setup_pkg::panel_s pnl;
  logic                   card_present;
  logic                   analog_prog;
  logic [NIN-1:0]         rise;
  assign rise = sync2_q & ~prev_q;
  assign pnl  = rise[NIN-1:2];
  assign card_present = sync2_q[1];
  assign analog_prog  = sync2_q[0];

  // ----------------------------------------------------------------------
  // Stored settings and state.
  // ----------------------------------------------------------------------
  menu_button_a_setup_pkg::iface_e  iface_q;
  menu_button_a_setup_pkg::baud_e   baud_q;
  menu_button_a_setup_pkg::cmd_language_item_e   cmd_language_item_q;
  menu_button_a_setup_pkg::mode_e   mode_q;
  logic [4:0]              addr_q;
  logic [7:0]              ip_q [4];
  logic [2:0]              pos_q;
  logic [1:0]              ip_idx_q;
  logic                    ip_edit_q;
  logic                    menu_q;
  logic                    fine_q;
  logic                    sys_armed_q;
  logic [31:0]             warn_cnt_q;
  logic                    warn_lock_q;
  logic [7:0]              blink_cnt_q;

  logic lan;
  logic scpi_only;
  logic [2:0] pos_last;
  logic [2:0] pos_baud;
  logic [2:0] pos_cmd_language_item;
  logic panel_locked;
  logic sw_wr;
  logic confirm;

  assign lan       = (iface_q == menu_button_a_setup_pkg::IFACE_LAN);
  assign scpi_only = lan || (iface_q == menu_button_a_setup_pkg::IFACE_OPT);
  assign pos_last  = lan ? menu_button_a_setup_pkg::POS_LAST_LAN
                         : menu_button_a_setup_pkg::POS_LAST_NORMAL;
  assign pos_baud  = lan ? menu_button_a_setup_pkg::POS_BAUD_LAN
                         : menu_button_a_setup_pkg::POS_BAUD_NORMAL;
  assign pos_cmd_language_item  = lan ? menu_button_a_setup_pkg::POS_CMD_LANGUAGE_ITEM_LAN
                         : menu_button_a_setup_pkg::POS_CMD_LANGUAGE_ITEM_NORMAL;
  assign panel_locked = (mode_q != menu_button_a_setup_pkg::MODE_LOCAL);
  assign sw_wr   = psel && penable && pwrite;
  assign confirm = menu_q && pnl.val_press && !panel_locked;

  // ----------------------------------------------------------------------
  // Menu navigation.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      menu_q    <= 1'b0;
      pos_q     <= '0;
      ip_edit_q <= 1'b0;
      ip_idx_q  <= '0;
    end else if (pnl.menu_button_a && !menu_q) begin
      menu_q    <= 1'b1;
      pos_q     <= '0;
      ip_edit_q <= 1'b0;
    end else if (menu_q && (pnl.menu_button_a || pnl.back_button)) begin
      if (ip_edit_q && pnl.back_button) begin
        ip_edit_q <= 1'b0;
      end else begin
        menu_q    <= 1'b0;
        ip_edit_q <= 1'b0;
      end
    end else if (menu_q) begin
      if (pnl.rot_sel_cw && pos_q < pos_last) begin
        pos_q     <= pos_q + 3'h1;
        ip_edit_q <= 1'b0;
      end else if (pnl.rot_sel_ccw && pos_q != 3'h0) begin
        pos_q     <= pos_q - 3'h1;
        ip_edit_q <= 1'b0;
      end
      if (lan && pos_q >= menu_button_a_setup_pkg::POS_IP_FIRST &&
          pos_q <= menu_button_a_setup_pkg::POS_IP_LAST) begin
        if (confirm) begin
          ip_idx_q  <= 2'(pos_q - menu_button_a_setup_pkg::POS_IP_FIRST);
          ip_edit_q <= !ip_edit_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Coarse and fine step mode.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fine_q <= 1'b0;
    end else if (pnl.fine_button) begin
      fine_q <= !fine_q;
    end
  end

  // ----------------------------------------------------------------------
  // Settings, from panel edits or software writes.
  // ----------------------------------------------------------------------
  logic [7:0] ip_step;
  assign ip_step = fine_q ? menu_button_a_setup_pkg::IP_STEP_FINE
                          : menu_button_a_setup_pkg::IP_STEP_COARSE;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      iface_q <= menu_button_a_setup_pkg::IFACE_RS232;
      addr_q  <= menu_button_a_setup_pkg::ADDR_RESET;
      baud_q  <= menu_button_a_setup_pkg::BAUD_9600;
      cmd_language_item_q  <= menu_button_a_setup_pkg::CMD_LANGUAGE_ITEM_SCPI;
      for (int i = 0; i < 4; i++) begin
        ip_q[i] <= '0;
      end
    end else begin
      if (confirm && pos_q == 3'h0) begin
        if (pnl.rot_val_cw) begin
          // Advance, skipping the optional choice without a card.
          if (iface_q == menu_button_a_setup_pkg::IFACE_LAN && card_present) begin
            iface_q <= menu_button_a_setup_pkg::IFACE_OPT;
          end else if (iface_q == menu_button_a_setup_pkg::IFACE_LAN ||
                       iface_q == menu_button_a_setup_pkg::IFACE_OPT) begin
            iface_q <= menu_button_a_setup_pkg::IFACE_RS232;
          end else begin
            iface_q <= menu_button_a_setup_pkg::iface_e'(iface_q + 3'h1);
          end
        end
      end
      if (menu_q && !panel_locked && ip_edit_q && lan) begin
        if (pnl.rot_val_cw) begin
          ip_q[ip_idx_q] <= (ip_q[ip_idx_q] > 8'hff - ip_step) ? 8'hff
                            : ip_q[ip_idx_q] + ip_step;
        end else if (pnl.rot_val_ccw) begin
          ip_q[ip_idx_q] <= (ip_q[ip_idx_q] < ip_step) ? 8'h00
                            : ip_q[ip_idx_q] - ip_step;
        end
      end
      if (menu_q && !panel_locked && pos_q == 3'h1) begin
        if (pnl.rot_val_cw && addr_q != menu_button_a_setup_pkg::ADDR_MAX) begin
          addr_q <= addr_q + 5'h1;
        end else if (pnl.rot_val_ccw && addr_q != 5'h0) begin
          addr_q <= addr_q - 5'h1;
        end
      end
      if (menu_q && !panel_locked && pos_q == pos_baud && !lan) begin
        if (pnl.rot_val_cw && baud_q != menu_button_a_setup_pkg::BAUD_115200) begin
          baud_q <= menu_button_a_setup_pkg::baud_e'(baud_q + 3'h1);
        end else if (pnl.rot_val_ccw &&
                     baud_q != menu_button_a_setup_pkg::BAUD_9600) begin
          baud_q <= menu_button_a_setup_pkg::baud_e'(baud_q - 3'h1);
        end
      end
      if (menu_q && !panel_locked && pos_q == pos_cmd_language_item && !scpi_only &&
          (pnl.rot_val_cw || pnl.rot_val_ccw)) begin
        cmd_language_item_q <= menu_button_a_setup_pkg::cmd_language_item_e'(!cmd_language_item_q);
      end
      if (sw_wr && paddr == menu_button_a_setup_pkg::OFS_IFACE &&
          pwdata[2:0] <= 3'(menu_button_a_setup_pkg::IFACE_OPT) &&
          (pwdata[2:0] != 3'(menu_button_a_setup_pkg::IFACE_OPT) || card_present)) begin
        iface_q <= menu_button_a_setup_pkg::iface_e'(pwdata[2:0]);
      end
      if (sw_wr && paddr == menu_button_a_setup_pkg::OFS_ADDR &&
          pwdata[31:0] <= 32'(menu_button_a_setup_pkg::ADDR_MAX)) begin
        addr_q <= pwdata[4:0];
      end
      if (sw_wr && paddr == menu_button_a_setup_pkg::OFS_IPV4) begin
        for (int i = 0; i < 4; i++) begin
          ip_q[i] <= pwdata[8*i +: 8];
        end
      end
      if (sw_wr && paddr == menu_button_a_setup_pkg::OFS_BAUD &&
          pwdata[2:0] <= 3'(menu_button_a_setup_pkg::BAUD_115200)) begin
        baud_q <= menu_button_a_setup_pkg::baud_e'(pwdata[2:0]);
      end
      if (sw_wr && paddr == menu_button_a_setup_pkg::OFS_CMD_LANGUAGE_ITEM) begin
        cmd_language_item_q <= menu_button_a_setup_pkg::cmd_language_item_e'(pwdata[0]);
      end
      // These overrides come last so they win over any write.
      if (lan) begin
        baud_q <= menu_button_a_setup_pkg::BAUD_115200;
      end
      if (scpi_only) begin
        cmd_language_item_q <= menu_button_a_setup_pkg::CMD_LANGUAGE_ITEM_SCPI;
      end
      if (iface_q == menu_button_a_setup_pkg::IFACE_OPT && !card_present) begin
        iface_q <= menu_button_a_setup_pkg::IFACE_RS232;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control mode and host commands.
  // ----------------------------------------------------------------------
  logic host_cmd;
  logic [1:0] host_mode_cmd;
  assign host_cmd = host_cmd_valid && !host_is_query;
  assign host_mode_cmd = (sw_wr && paddr == menu_button_a_setup_pkg::OFS_HOSTCMD)
                         ? pwdata[1:0] : 2'h0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q      <= menu_button_a_setup_pkg::MODE_LOCAL;
      sys_armed_q <= 1'b0;
    end else begin
      if (pnl.system_button) begin
        sys_armed_q <= 1'b1;
      end else if (pnl.val_press) begin
        sys_armed_q <= 1'b0;
      end
      case (mode_q)
        menu_button_a_setup_pkg::MODE_LOCAL: begin
          if (host_mode_cmd == 2'(menu_button_a_setup_pkg::HCMD_LOCKOUT)) begin
            mode_q <= menu_button_a_setup_pkg::MODE_LOCKOUT;
          end else if (host_cmd) begin
            mode_q <= menu_button_a_setup_pkg::MODE_REMOTE;
          end
        end
        menu_button_a_setup_pkg::MODE_REMOTE: begin
          if (host_mode_cmd == 2'(menu_button_a_setup_pkg::HCMD_LOCKOUT)) begin
            mode_q <= menu_button_a_setup_pkg::MODE_LOCKOUT;
          end else if (host_mode_cmd == 2'(menu_button_a_setup_pkg::HCMD_LOCAL) ||
                       (sys_armed_q && pnl.val_press)) begin
            mode_q <= menu_button_a_setup_pkg::MODE_LOCAL;
          end
        end
        menu_button_a_setup_pkg::MODE_LOCKOUT: begin
          if (host_mode_cmd == 2'(menu_button_a_setup_pkg::HCMD_REMOTE)) begin
            mode_q <= menu_button_a_setup_pkg::MODE_REMOTE;
          end
        end
        default: mode_q <= menu_button_a_setup_pkg::MODE_LOCAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      host_cmd_exec     <= 1'b0;
      host_query_answer <= 1'b0;
    end else begin
      host_cmd_exec     <= host_cmd &&
                           !(analog_prog && host_is_setpoint);
      host_query_answer <= host_cmd_valid && host_is_query;
    end
  end

  // ----------------------------------------------------------------------
  // Warnings and acknowledge blink.
  // ----------------------------------------------------------------------
  logic attempt;
  assign attempt = panel_locked && (pnl.rot_val_cw || pnl.rot_val_ccw ||
                   (pnl.val_press && !sys_armed_q));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      warn_cnt_q  <= '0;
      warn_lock_q <= 1'b0;
    end else if (attempt) begin
      warn_cnt_q  <= 32'(WARN_CYCLES);
      warn_lock_q <= (mode_q == menu_button_a_setup_pkg::MODE_LOCKOUT);
    end else if (warn_cnt_q != '0) begin
      warn_cnt_q <= warn_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blink_cnt_q <= '0;
    end else if (confirm) begin
      blink_cnt_q <= 8'(menu_button_a_setup_pkg::BLINK_CYCLES);
    end else if (blink_cnt_q != '0) begin
      blink_cnt_q <= blink_cnt_q - 8'h1;
    end
  end

  assign remote_led      = panel_locked;
  assign remote_warning  = (warn_cnt_q != '0) && !warn_lock_q;
  assign lockout_warning = (warn_cnt_q != '0) && warn_lock_q;
  assign blink           = (blink_cnt_q != '0);
  assign menu_active     = menu_q;
  assign menu_pos        = pos_q;
  assign fine_mode       = fine_q;

  // ----------------------------------------------------------------------
  // APB read side.
  // ----------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        menu_button_a_setup_pkg::OFS_IFACE:  prdata <= {29'h0, iface_q};
        menu_button_a_setup_pkg::OFS_ADDR:   prdata <= {27'h0, addr_q};
        menu_button_a_setup_pkg::OFS_IPV4:   prdata <= {ip_q[3], ip_q[2],
                                               ip_q[1], ip_q[0]};
        menu_button_a_setup_pkg::OFS_BAUD:   prdata <= {29'h0, baud_q};
        menu_button_a_setup_pkg::OFS_CMD_LANGUAGE_ITEM:   prdata <= {31'h0, cmd_language_item_q};
        menu_button_a_setup_pkg::OFS_MODE:   prdata <= {30'h0, mode_q};
        menu_button_a_setup_pkg::OFS_STATUS: prdata <= {27'h0, card_present,
                                               analog_prog, fine_q,
                                               menu_q, blink};
        default:                    prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  localparam int BLINK_DLY = menu_button_a_setup_pkg::BLINK_CYCLES;

  a_lan_baud_lock: assert property (
    @(posedge ref_clk) disable iff (reset)
    lan |=> baud_q == menu_button_a_setup_pkg::BAUD_115200)
    else $error("baud not forced under LAN");
  a_cmd_language_item_scpi: assert property (
    @(posedge ref_clk) disable iff (reset)
    scpi_only |=> cmd_language_item_q == menu_button_a_setup_pkg::CMD_LANGUAGE_ITEM_SCPI)
    else $error("legacy language with LAN or optional");
  a_addr_range: assert property (
    @(posedge ref_clk) disable iff (reset)
    sw_wr && paddr == menu_button_a_setup_pkg::OFS_ADDR && !menu_q &&
    pwdata > 32'(menu_button_a_setup_pkg::ADDR_MAX) |=> $stable(addr_q))
    else $error("address beyond range accepted");
  a_local_cmd_remote: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_q == menu_button_a_setup_pkg::MODE_LOCAL && host_cmd && host_mode_cmd == 2'h0
    |=> mode_q == menu_button_a_setup_pkg::MODE_REMOTE &&
        (host_cmd_exec || analog_prog))
    else $error("command did not move to remote");
  a_query_stays: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_q == menu_button_a_setup_pkg::MODE_LOCAL && host_cmd_valid && host_is_query
    && host_mode_cmd == 2'h0 |=> mode_q == menu_button_a_setup_pkg::MODE_LOCAL
    && host_query_answer)
    else $error("query changed mode");
  a_lock_entry: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_q != menu_button_a_setup_pkg::MODE_LOCKOUT ##1
    mode_q == menu_button_a_setup_pkg::MODE_LOCKOUT
    |-> $past(host_mode_cmd) == 2'(menu_button_a_setup_pkg::HCMD_LOCKOUT))
    else $error("lockout entered without host command");
  a_lock_exit: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_q == menu_button_a_setup_pkg::MODE_LOCKOUT |=>
    mode_q != menu_button_a_setup_pkg::MODE_LOCAL)
    else $error("lockout left to local");
  a_warn_start: assert property (
    @(posedge ref_clk) disable iff (reset)
    attempt && mode_q == menu_button_a_setup_pkg::MODE_REMOTE
    |=> remote_warning [*2])
    else $error("remote warning missing");
  a_blink_once: assert property (
    @(posedge ref_clk) disable iff (reset)
    confirm |=> blink ##BLINK_DLY (!blink || confirm))
    else $error("blink length wrong");

endmodule : menu_button_a_setup
`default_nettype wire

// File: sim/host_model.sv
// Remote host model that sends commands and queries to the block.
`default_nettype none
module host_model (
  input  wire logic ref_clk,
  input  wire logic host_cmd_exec,
  input  wire logic host_query_answer,
  output var  logic host_cmd_valid,
  output var  logic host_is_query,
  output var  logic host_is_setpoint
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Message driver
  // ----------------------------------------------------------------------
  initial begin
    host_cmd_valid = 1'b0;
    host_is_query = 1'b0;
    host_is_setpoint = 1'b0;
  end
  // Sends one message and returns what the block pulsed the cycle after.
  task send(input logic q, input logic sp, output logic ex,
            output logic an);
    host_cmd_valid <= 1'b1;
    host_is_query <= q;
    host_is_setpoint <= sp;
    @(posedge ref_clk);
    host_cmd_valid <= 1'b0;
    host_is_query <= 1'b0;
    host_is_setpoint <= 1'b0;
    @(posedge ref_clk);
    ex = host_cmd_exec;
    an = host_query_answer;
    @(posedge ref_clk);
  endtask : send
endmodule : host_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking testbench for the communication setup block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk, reset, psel, penable, pwrite, card;
  logic                   pready, pslverr, exec_p, ans_p, hv, hq, hs;
  logic                   led, rwarn, lwarn, blink, menu_on, fine, ex, an;
  logic                   ana;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata;
  logic [2:0]             pos;
  logic [8:0]             pan;
  int                     fail_count, compares;
  // ----------------------------------------------------------------------
  // Clock, block and host
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  menu_button_a_setup #(.WARN_CYCLES(50)) dut (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_raw(menu_button_a_setup_pkg::panel_s'(pan)), .card_present_raw(card),
    .analog_prog_raw(ana), .host_cmd_valid(hv), .host_is_query(hq),
    .host_is_setpoint(hs), .host_cmd_exec(exec_p),
    .host_query_answer(ans_p), .remote_led(led), .remote_warning(rwarn),
    .lockout_warning(lwarn), .blink(blink), .menu_active(menu_on),
    .menu_pos(pos), .fine_mode(fine));
  host_model host (.ref_clk(ref_clk), .host_cmd_exec(exec_p),
    .host_query_answer(ans_p), .host_cmd_valid(hv), .host_is_query(hq),
    .host_is_setpoint(hs));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task wrap_up;
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask : rdc
  task tap(input logic [8:0] m, input int k);
    repeat (k) begin
      pan <= m;
      repeat (3) @(posedge ref_clk);
      pan <= 9'h000;
      repeat (5) @(posedge ref_clk);
    end
  endtask : tap
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    rdc("addr", 8'h04, 32'h6);
    rdc("baud", 8'h0c, 32'h0);
    wr(8'h04, 32'h1f);
    wr(8'h04, 32'h20);
    rdc("addr", 8'h04, 32'h1f);
    wr(8'h00, 32'h4);
    rdc("iface", 8'h00, 32'h0);
    card <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(8'h00, 32'h4);
    wr(8'h10, 32'h1);
    rdc("cmd_language_item", 8'h10, 32'h0);
    wr(8'h00, 32'h5);
    rdc("iface", 8'h00, 32'h4);
    wr(8'h20, 32'h5);
    rdc("unmapped", 8'h20, 32'h0);
    chk("pslverr", 32'h0, 32'(pslverr));
  endtask : t_regs
  task t_lan;
    wr(8'h00, 32'h3);
    wr(8'h0c, 32'h0);
    rdc("baud", 8'h0c, 32'h4);
    wr(8'h08, 32'hff000a01);
    tap(9'h008, 1);
    tap(9'h100, 2);
    tap(9'h010, 1);
    tap(9'h040, 1);
    tap(9'h002, 1);
    tap(9'h040, 1);
    tap(9'h010, 1);
    chk("blink", 32'h1, 32'(blink));
    chk("fine", 32'h1, 32'(fine));
    repeat (20) @(posedge ref_clk);
    chk("blink", 32'h0, 32'(blink));
    tap(9'h100, 3);
    chk("pos", 32'h5, 32'(pos));
    tap(9'h100, 2);
    chk("pos", 32'h6, 32'(pos));
    tap(9'h008, 1);
    rdc("ipv4", 8'h08, 32'hff000a0c);
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h1);
    rdc("baud", 8'h0c, 32'h1);
    rdc("cmd_language_item", 8'h10, 32'h1);
  endtask : t_lan
  task t_menu;
    tap(9'h008, 1);
    chk("menu", 32'h1, 32'(menu_on));
    tap(9'h100, 2);
    chk("pos", 32'h2, 32'(pos));
    tap(9'h100, 2);
    chk("pos", 32'h3, 32'(pos));
    tap(9'h004, 1);
    chk("menu", 32'h0, 32'(menu_on));
    tap(9'h008, 1);
    tap(9'h050, 1);
    tap(9'h008, 1);
    chk("menu", 32'h0, 32'(menu_on));
    rdc("iface", 8'h00, 32'h1);
  endtask : t_menu
  task t_modes;
    host.send(1'b1, 1'b0, ex, an);
    chk("answer", 32'h2, 32'({an, ex}));
    rdc("mode", 8'h14, 32'h0);
    host.send(1'b0, 1'b0, ex, an);
    chk("exec", 32'h1, 32'({an, ex}));
    rdc("mode", 8'h14, 32'h1);
    tap(9'h040, 1);
    chk("rwarn", 32'h3, 32'({led, rwarn}));
    repeat (60) @(posedge ref_clk);
    chk("rwarn", 32'h0, 32'(rwarn));
    wr(8'h18, 32'h3);
    tap(9'h040, 1);
    chk("lwarn", 32'h3, 32'({led, lwarn}));
    tap(9'h001, 1);
    tap(9'h010, 1);
    wr(8'h18, 32'h1);
    rdc("mode", 8'h14, 32'h2);
    wr(8'h18, 32'h2);
    rdc("mode", 8'h14, 32'h1);
    tap(9'h001, 1);
    tap(9'h010, 1);
    rdc("mode", 8'h14, 32'h0);
    chk("led", 32'h0, 32'(led));
    ana <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host.send(1'b0, 1'b1, ex, an);
    chk("setpoint", 32'h0, 32'({an, ex}));
    host.send(1'b0, 1'b0, ex, an);
    chk("other", 32'h1, 32'({an, ex}));
  endtask : t_modes
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pan = 9'h000;
    card = 1'b0;
    ana = 1'b0;
    fail_count = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_lan();
    t_menu();
    t_modes();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
